/* urx_rx.sv */
// Receive data recovery with multiprocessor address filter
//
// What this block does
// - Recovery steps 16 states per bit, or 8 in double speed.
// - Votes use samples 8,9,10 normally, 4,5,6 in double speed.
// - Bit is one when two or three votes are high, else zero.
// - Recover every bit through first stop bit; ignore later stop bits.
// - First stop bit voted; a zero sets the stored frame error flag.
// - Next falling edge accepted right after stop vote; later in double speed.
// - With filter enabled, non-address frames are dropped, never buffered.
// - Filter enable leaves the transmitter untouched.
// - Frame type is first stop bit, or ninth bit for 9-bit frames.
// - Frame type one means address, zero means data.
// - Accepted address frame sets receive complete as usual.
// - Transmitter and receiver share one character size setting.
// - Line sampled at 16x baud, or 8x in double speed.
// - Start bit voted after the edge; high majority rejects it.
`timescale 1ns/1ps
module urx_rx
  import urx_pkg::*;
#(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Serial line
  input  wire logic       rxd,
  // Transmitter side
  input  wire logic       tx_done,
  output logic      [2:0] char_size_select,
  output logic            two_stop_select,
  output logic            double_speed_select,
  // Status
  output logic            rx_complete_flag
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  urx_ctrl_t      ctrl_r;
  logic [7:0]     baud_r;
  logic [7:0]     baud_cnt_r;
  logic           tick;
  logic           mpcm_r;
  logic           txc_r;
  logic           dor_r;
  urx_state_t     state_r;
  logic [4:0]     cnt_r;
  logic [3:0]     bit_idx_r;
  logic [1:0]     v_r;
  logic [8:0]     sr_r;
  logic           stop_r;
  logic           done_r;
  logic           fin_stop_r;
  logic [8:0]     fin_data_r;
  logic [4:0]     spb;
  logic [4:0]     vfirst;
  logic [4:0]     vmid;
  logic [4:0]     vlast;
  logic [4:0]     stop_end;
  logic [3:0]     nbits;
  logic           vote_now;
  logic           ftype;
  logic           accept;
  logic           push;
  logic           pop;
  logic [PW-1:0]  wr_ptr_r;
  logic [PW-1:0]  rd_ptr_r;
  logic [CW-1:0]  count_r;
  urx_frame_t     wr_frame;
  urx_frame_t     rd_frame;
  logic [1:0]     rd_sel_r;
  logic           rd_mem_r;
  logic [7:0]     rbase_r;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= urx_ctrl_t'(CTRL_RST[5:0]);
      baud_r <= BAUD_RST;
    end else if (reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl_r <= urx_ctrl_t'(reg_wdata[5:0]);
    end else if (reg_wr && reg_addr == ADDR_BAUD) begin
      baud_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mpcm_r <= MPCM_RST;
    end else if (reg_wr && reg_addr == ADDR_STATUS) begin
      mpcm_r <= reg_wdata[ST_MPCM];
    end
  end

  // Done pulse sets; writing one clears; set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txc_r <= 1'b0;
    end else if (tx_done) begin
      txc_r <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[ST_TXC]) begin
      txc_r <= 1'b0;
    end
  end

  // Transmitter sees size, stop and double speed setting, never the filter enable
  assign char_size_select    = ctrl_r.size;
  assign two_stop_select     = ctrl_r.two_stop;
  assign double_speed_select = ctrl_r.dbl;

  // ----------------------------------------------------------------
  // Oversampling tick and sample numbering
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_cnt_r <= '0;
    end else if (tick) begin
      baud_cnt_r <= baud_r;
    end else begin
      baud_cnt_r <= baud_cnt_r - 8'h01;
    end
  end

  assign tick     = (baud_cnt_r == 8'h00);
  assign spb      = ctrl_r.dbl ? SPB_DBL : SPB_NORM;
  assign vfirst   = ctrl_r.dbl ? VOTE_DBL : VOTE_NORM;
  assign vmid     = vfirst + 5'h01;
  assign vlast    = vfirst + 5'h02;
  assign stop_end = ctrl_r.dbl ? STOP_END_DBL : vlast;
  assign nbits    = urx_nbits(ctrl_r.size);
  assign vote_now = urx_maj3(v_r[0], v_r[1], rxd);

  // ----------------------------------------------------------------
  // Recovery state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= URX_IDLE;
      cnt_r   <= '0;
    end else if (!ctrl_r.rx_en) begin
      state_r <= URX_IDLE;
      cnt_r   <= '0;
    end else if (tick) begin
      case (state_r)
        URX_IDLE: begin
          if (!rxd) begin
            state_r <= URX_START;
            cnt_r   <= 5'h02;
          end
        end
        URX_START: begin
          if (cnt_r == vlast && vote_now) begin
            state_r <= URX_IDLE;
            cnt_r   <= '0;
          end else if (cnt_r == spb) begin
            state_r <= URX_DATA;
            cnt_r   <= 5'h01;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        URX_DATA: begin
          if (cnt_r == spb) begin
            cnt_r <= 5'h01;
            if (bit_idx_r == nbits) begin
              state_r <= URX_STOP;
            end
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        URX_STOP: begin
          if (cnt_r == stop_end) begin
            state_r <= URX_IDLE;
            cnt_r   <= '0;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= URX_IDLE;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_idx_r <= '0;
    end else if (tick && state_r == URX_START) begin
      bit_idx_r <= '0;
    end else if (tick && state_r == URX_DATA && cnt_r == vlast) begin
      bit_idx_r <= bit_idx_r + 4'h1;
    end
  end

  // Center samples held for the vote
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      v_r <= '0;
    end else if (tick && state_r != URX_IDLE && cnt_r == vfirst) begin
      v_r[0] <= rxd;
    end else if (tick && state_r != URX_IDLE && cnt_r == vmid) begin
      v_r[1] <= rxd;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_r <= '0;
    end else if (tick && state_r == URX_DATA && cnt_r == vlast) begin
      sr_r <= {vote_now, sr_r[8:1]};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_r <= 1'b1;
    end else if (tick && state_r == URX_STOP && cnt_r == vlast) begin
      stop_r <= vote_now;
    end
  end

  // Frame completion, data right aligned
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_r     <= 1'b0;
      fin_stop_r <= 1'b1;
      fin_data_r <= '0;
    end else begin
      done_r <= ctrl_r.rx_en && tick && state_r == URX_STOP && cnt_r == stop_end;
      if (tick && state_r == URX_STOP && cnt_r == stop_end) begin
        fin_stop_r <= (cnt_r == vlast) ? vote_now : stop_r;
        fin_data_r <= sr_r >> (BITS_NINE - nbits);
      end
    end
  end

  // ----------------------------------------------------------------
  // Address filter and receive buffer
  // ----------------------------------------------------------------
  assign ftype  = (ctrl_r.size == SIZE_NINE) ? fin_data_r[8] : fin_stop_r;
  assign accept = !(mpcm_r && !ftype);
  assign push   = done_r && accept && ctrl_r.rx_en && count_r < CW'(DEPTH);
  assign pop    = reg_rd && reg_addr == ADDR_DATA && count_r != '0;

  assign wr_frame.fe   = !fin_stop_r;
  assign wr_frame.data = fin_data_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (!ctrl_r.rx_en) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + CW'(1);
      end else if (pop && !push) begin
        count_r <= count_r - CW'(1);
      end
    end
  end

  // Overrun kept only for accepted frames
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dor_r <= 1'b0;
    end else if (done_r && accept && ctrl_r.rx_en && !push) begin
      dor_r <= 1'b1;
    end else if (push) begin
      dor_r <= 1'b0;
    end
  end

  assign rx_complete_flag = (count_r != '0);

  urx_rxbuf #(
    .W     ($bits(urx_frame_t)),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk     (clk),
    .arst_n  (arst_n),
    .wr_en   (push),
    .wr_addr (wr_ptr_r),
    .wr_data (wr_frame),
    .rd_addr (rd_ptr_r),
    .rd_q    (rd_frame)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_sel_r <= '0;
      rd_mem_r <= 1'b0;
      rbase_r  <= '0;
    end else begin
      rd_sel_r <= reg_addr;
      rd_mem_r <= reg_rd && count_r != '0 &&
                  (reg_addr == ADDR_DATA || reg_addr == ADDR_STATUS);
      rbase_r  <= '0;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_STATUS: begin
            rbase_r[ST_RXC]  <= (count_r != '0);
            rbase_r[ST_TXC]  <= txc_r;
            rbase_r[ST_DOR]  <= dor_r;
            rbase_r[ST_MPCM] <= mpcm_r;
          end
          ADDR_CTRL: rbase_r <= {2'b00, ctrl_r};
          ADDR_BAUD: rbase_r <= baud_r;
          default:   rbase_r <= '0;
        endcase
      end
    end
  end

  always_comb begin
    reg_rdata = rbase_r;
    if (rd_mem_r && rd_sel_r == ADDR_DATA) begin
      reg_rdata = rd_frame.data[7:0];
    end else if (rd_mem_r) begin
      reg_rdata[ST_FE]    = rd_frame.fe;
      reg_rdata[ST_NINTH] = rd_frame.data[8];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_bit_end;
    tick && ctrl_r.rx_en && (state_r == URX_START || state_r == URX_DATA) && cnt_r == spb;
  endsequence

  sequence s_start_vote;
    tick && ctrl_r.rx_en && state_r == URX_START && cnt_r == vlast;
  endsequence

  sequence s_stop_vote;
    tick && ctrl_r.rx_en && !ctrl_r.dbl && state_r == URX_STOP && cnt_r == vlast;
  endsequence

  a_sample_wrap: assert property (@(posedge clk) disable iff (!arst_n)
    s_bit_end ##0 !(state_r == URX_START && vote_now) |=> cnt_r == 5'h01)
    else $error("sample number did not restart at one");

  a_first_vote: assert property (@(posedge clk) disable iff (!arst_n)
    tick && ctrl_r.rx_en && state_r == URX_DATA && cnt_r == vfirst
      |=> v_r[0] == $past(rxd))
    else $error("first voting sample not captured");

  a_bit_majority: assert property (@(posedge clk) disable iff (!arst_n)
    tick && ctrl_r.rx_en && state_r == URX_DATA && cnt_r == vlast
      |=> sr_r[8] == (($past(v_r[0]) && $past(v_r[1])) ||
                      ($past(rxd) && ($past(v_r[0]) || $past(v_r[1])))))
    else $error("bit value not the majority of center samples");

  a_start_reject: assert property (@(posedge clk) disable iff (!arst_n)
    s_start_vote ##0 vote_now |=> state_r == URX_IDLE)
    else $error("high start vote not rejected");

  a_stop_error: assert property (@(posedge clk) disable iff (!arst_n)
    s_stop_vote |=> done_r && fin_stop_r == $past(vote_now))
    else $error("stop vote not carried to frame end");

  a_early_start: assert property (@(posedge clk) disable iff (!arst_n)
    s_stop_vote |=> state_r == URX_IDLE ##1 state_r != URX_STOP)
    else $error("idle not reached right after stop vote");

  a_filter_drop: assert property (@(posedge clk) disable iff (!arst_n)
    done_r && mpcm_r && !ftype && !pop |=> $stable(count_r))
    else $error("data frame stored while filter enabled");

  a_drop_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    done_r && mpcm_r && !ftype |=> $stable(dor_r))
    else $error("dropped frame changed overrun flag");

  a_addr_accept: assert property (@(posedge clk) disable iff (!arst_n)
    done_r && ctrl_r.rx_en && ftype && count_r == '0 |=> rx_complete_flag)
    else $error("address frame did not set receive complete");

  a_ninth_type: assert property (@(posedge clk) disable iff (!arst_n)
    done_r && ctrl_r.rx_en && mpcm_r && ctrl_r.size == SIZE_NINE &&
      fin_data_r[8] && count_r == '0 |=> count_r == CW'(1))
    else $error("ninth bit address frame not stored");

endmodule

/* urx_pkg.sv */
// Constants, types and helpers shared by the receive recovery block
package urx_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CTRL   = 2'h1;
  localparam logic [1:0] ADDR_BAUD   = 2'h2;
  localparam logic [1:0] ADDR_DATA   = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_MPCM  = 0;
  localparam int ST_NINTH = 1;
  localparam int ST_DOR   = 3;
  localparam int ST_FE    = 4;
  localparam int ST_TXC   = 6;
  localparam int ST_RXC   = 7;
  localparam int CT_DBL   = 0;
  localparam int CT_SIZE  = 1;
  localparam int CT_TWO   = 4;
  localparam int CT_RXEN  = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h26;
  localparam logic [7:0] BAUD_RST = 8'h0C;
  localparam logic       MPCM_RST = 1'b0;

  // ----------------------------------------------------------------
  // Sampling figures
  // ----------------------------------------------------------------
  localparam logic [4:0] SPB_NORM     = 5'h10;
  localparam logic [4:0] SPB_DBL      = 5'h08;
  localparam logic [4:0] VOTE_NORM    = 5'h08;
  localparam logic [4:0] VOTE_DBL     = 5'h04;
  localparam logic [4:0] STOP_END_DBL = 5'h07;
  localparam logic [2:0] SIZE_NINE    = 3'h7;
  localparam logic [2:0] SIZE_EIGHT   = 3'h3;
  localparam logic [3:0] BITS_MIN     = 4'h5;
  localparam logic [3:0] BITS_EIGHT   = 4'h8;
  localparam logic [3:0] BITS_NINE    = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    URX_IDLE  = 2'b00,
    URX_START = 2'b01,
    URX_DATA  = 2'b11,
    URX_STOP  = 2'b10
  } urx_state_t;

  typedef struct packed {
    logic       fe;
    logic [8:0] data;
  } urx_frame_t;

  typedef struct packed {
    logic       rx_en;
    logic       two_stop;
    logic [2:0] size;
    logic       dbl;
  } urx_ctrl_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic urx_maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [3:0] urx_nbits(input logic [2:0] size);
    if (size == SIZE_NINE) begin
      return BITS_NINE;
    end
    if (size <= SIZE_EIGHT) begin
      return BITS_MIN + {1'b0, size};
    end
    return BITS_EIGHT;
  endfunction

endpackage

/* urx_rxbuf.sv */
// Small frame store with registered read data
`timescale 1ns/1ps
module urx_rxbuf #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [W-1:0]             wr_data,
  // Read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [W-1:0]             rd_q
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= '0;
    end else begin
      rd_q <= mem[rd_addr];
    end
  end

endmodule

/* urx_line_model.sv */
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module urx_line_model (
  // Clock
  input  wire logic clk,
  // Transmitter setting
  input  wire logic two_stop_select,
  // Serial line
  output logic      rxd
);
  // ----------------------------------------------------------------
  // Line control
  // ----------------------------------------------------------------
  initial begin
    rxd = 1'b1;
  end

  task automatic hold(input logic v, input int n);
    repeat (n) begin
      @(posedge clk);
      rxd <= v;
    end
  endtask

  // Start, data LSB first, first stop; gn cycles flipped from mid-bit of bit gbit
  task automatic send(input logic [8:0] data, input int nbits, input int spb,
                      input logic stop, input int stop_len, input int gbit,
                      input int gn);
    logic       v;
    logic [8:0] sh;
    int         len;
    sh = data;
    for (int i = 0; i <= nbits + 1; i++) begin
      if (i == 0) begin
        v = 1'b0;
      end else if (i <= nbits) begin
        v = sh[0];
        sh = sh >> 1;
      end else begin
        v = stop;
      end
      len = (i == nbits + 1) ? stop_len : spb;
      for (int c = 0; c < len; c++) begin
        @(posedge clk);
        rxd <= ((i == gbit) && (c >= spb / 2) && (c < spb / 2 + gn)) ? ~v : v;
      end
    end
    if (two_stop_select && (stop_len == spb)) begin
      hold(1'b1, spb);
    end
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the receive recovery block
`timescale 1ns/1ps
module testbench;
  import urx_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk       = 1'b0;
  logic       arst_n    = 1'b0;
  logic [1:0] reg_addr  = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       tx_done   = 1'b0;
  logic [7:0] reg_rdata;
  logic       rxd;
  logic [2:0] char_size_select;
  logic       two_stop_select;
  logic       double_speed_select;
  logic       rx_complete_flag;
  logic [7:0] d;
  int         err_count = 0;
  int         cmp_count = 0;

  always #20 clk = ~clk;

  urx_rx #(.DEPTH(2)) dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd),
    .tx_done(tx_done), .char_size_select(char_size_select),
    .two_stop_select(two_stop_select), .double_speed_select(double_speed_select),
    .rx_complete_flag(rx_complete_flag)
  );

  urx_line_model tx (.clk(clk), .two_stop_select(two_stop_select), .rxd(rxd));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  task automatic wait_rxc();
    for (int n = 0; n < 400 && rx_complete_flag !== 1'b1; n++) begin
      @(posedge clk);
    end
    if (rx_complete_flag !== 1'b1) begin
      chk(rx_complete_flag, 9'h001);
      close_out();
    end
  endtask

  // Status first, then data, which pops the frame
  task automatic get_frame(input logic [7:0] st, input logic [7:0] dat);
    logic [7:0] v;
    wait_rxc();
    rd(ADDR_STATUS, v);
    chk(v, st);
    rd(ADDR_DATA, v);
    chk(v, dat);
  endtask

  task automatic none_left();
    repeat (4) @(posedge clk);
    chk(rx_complete_flag, 9'h000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_CTRL, d);
    chk(d, CTRL_RST);
    rd(ADDR_BAUD, d);
    chk(d, BAUD_RST);
    rd(ADDR_STATUS, d);
    chk(d, 8'h00);
    rd(ADDR_DATA, d);
    chk(d, 8'h00);
    chk({two_stop_select, double_speed_select, rx_complete_flag, 3'h0, char_size_select},
        9'h003);
    wr(ADDR_BAUD, 8'h00);
    repeat (16) @(posedge clk);
  endtask

  task automatic t_normal();
    tx.send(9'h0A5, 8, 16, 1'b1, 16, -1, 0);
    get_frame(8'h80, 8'hA5);
    none_left();
  endtask

  task automatic t_vote();
    tx.send(9'h05A, 8, 16, 1'b1, 16, 3, 1);
    tx.send(9'h05A, 8, 16, 1'b1, 16, 3, 2);
    get_frame(8'h80, 8'h5A);
    get_frame(8'h80, 8'h5E);
  endtask

  task automatic t_spike();
    tx.hold(1'b0, 8);
    tx.hold(1'b1, 40);
    chk(rx_complete_flag, 9'h000);
  endtask

  task automatic t_frame_err();
    tx.send(9'h033, 8, 16, 1'b0, 16, -1, 0);
    tx.hold(1'b1, 24);
    get_frame(8'h90, 8'h33);
    tx.send(9'h0CC, 8, 16, 1'b1, 16, 9, 1);
    get_frame(8'h80, 8'hCC);
  endtask

  task automatic t_back2back();
    tx.send(9'h081, 8, 16, 1'b1, 10, -1, 0);
    tx.send(9'h07E, 8, 16, 1'b1, 16, -1, 0);
    get_frame(8'h80, 8'h81);
    get_frame(8'h80, 8'h7E);
  endtask

  task automatic t_double();
    wr(ADDR_CTRL, 8'h27);
    chk(double_speed_select, 9'h001);
    tx.send(9'h0C3, 8, 8, 1'b1, 7, -1, 0);
    tx.send(9'h03C, 8, 8, 1'b1, 8, 2, 1);
    get_frame(8'h80, 8'hC3);
    get_frame(8'h80, 8'h3C);
    wr(ADDR_CTRL, 8'h26);
  endtask

  task automatic t_filter_nine();
    wr(ADDR_CTRL, 8'h2E);
    chk(char_size_select, 9'h007);
    wr(ADDR_STATUS, 8'h01);
    tx.send(9'h011, 9, 16, 1'b1, 16, -1, 0);
    none_left();
    tx.send(9'h1A0, 9, 16, 1'b1, 16, -1, 0);
    tx.send(9'h1A1, 9, 16, 1'b1, 16, -1, 0);
    tx.send(9'h022, 9, 16, 1'b1, 16, -1, 0);
    get_frame(8'h83, 8'hA0);
    get_frame(8'h83, 8'hA1);
    none_left();
    wr(ADDR_STATUS, 8'h00);
    tx.send(9'h055, 9, 16, 1'b1, 16, -1, 0);
    get_frame(8'h80, 8'h55);
    wr(ADDR_STATUS, 8'h01);
    tx.send(9'h066, 9, 16, 1'b1, 16, -1, 0);
    none_left();
  endtask

  task automatic t_filter_eight();
    wr(ADDR_CTRL, 8'h36);
    chk(two_stop_select, 9'h001);
    tx.send(9'h0F0, 8, 16, 1'b0, 16, -1, 0);
    none_left();
    rd(ADDR_STATUS, d);
    chk(d, 8'h01);
    tx.send(9'h0F1, 8, 16, 1'b1, 16, -1, 0);
    get_frame(8'h81, 8'hF1);
  endtask

  task automatic t_tx_side();
    @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, d);
    chk(d, 8'h40);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, d);
    chk(d, 8'h41);
    chk({two_stop_select, double_speed_select, 4'h0, char_size_select}, 9'h103);
    wr(ADDR_STATUS, 8'h40);
    rd(ADDR_STATUS, d);
    chk(d, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_normal();
    t_vote();
    t_spike();
    t_frame_err();
    t_back2back();
    t_double();
    t_filter_nine();
    t_filter_eight();
    t_tx_side();
    close_out();
  end
endmodule
